// File: design/kshcp_pkg.sv
// Purpose: constants shared by the key-scan host command port
// Assumes: 25 MHz system clock, bus pins sampled by that clock
// Notes:   command codes, bit positions, status codes, buffer depth and setting defaults live here
package kshcp_pkg;
  localparam logic [6:0] SLAVE_ADDR      = 7'h51;      // 0xa2/0xa3 with direction bit
  localparam logic [7:0] CMD_EVENT_READ  = 8'h20;
  localparam logic [7:0] CMD_REPEAT_READ = 8'h21;
  localparam logic [7:0] CMD_DEBOUNCE    = 8'h22;
  localparam logic [7:0] CMD_READ_INT    = 8'hD0;
  localparam logic [7:0] CMD_PIN_INT_EN  = 8'hD1;
  localparam logic [7:0] CMD_READ_STAT   = 8'hE0;
  localparam logic [7:0] CMD_SCAN_REQ    = 8'hE3;
  localparam logic [7:0] CMD_ACTIVE      = 8'hE4;
  localparam logic [7:0] CMD_READ_ERR    = 8'hF0;
  // interrupt code bit positions
  localparam int INT_KEY_BIT  = 0;
  localparam int INT_PIN0_BIT = 1;
  localparam int INT_PIN1_BIT = 2;
  localparam int INT_ERR_BIT  = 3;
  // error code bit positions
  localparam int ERR_EARLY_BIT = 0;
  localparam int ERR_INVAL_BIT = 1;
  localparam int ERR_KEYS_BIT  = 2;
  localparam int ERR_LOST_BIT  = 4;
  localparam int ERR_OVF_BIT   = 6;
  // status codes
  localparam logic [7:0] STAT_RESET = 8'h00;
  localparam logic [7:0] STAT_WAKE  = 8'h02;
  localparam logic [7:0] STAT_ACK   = 8'h06;
  localparam logic [7:0] STAT_NACK  = 8'h15;
  localparam logic [7:0] EMPTY_CODE = 8'h00;
  // event buffer
  localparam int FIFO_DEPTH = 14;
  localparam int PTR_W      = 4;
  // timing settings, in units of about 4 ms steps
  localparam logic [7:0] DEBOUNCE_RST = 8'h03;         // about 12 ms
  localparam logic [7:0] ACTIVE_RST   = 8'h7D;         // about 500 ms
  localparam int ACTIVE_STEP_US = 4000;
  localparam int CLK_MHZ        = 25;
  localparam int STEP_CYCLES    = ACTIVE_STEP_US * CLK_MHZ;
  // transaction state
  typedef enum logic [2:0] {
    KSHCP_IDLE = 3'b000,
    KSHCP_ADDR = 3'b001,
    KSHCP_AACK = 3'b011,
    KSHCP_RX   = 3'b010,
    KSHCP_RACK = 3'b110,
    KSHCP_TX   = 3'b111,
    KSHCP_TACK = 3'b101,
    KSHCP_WAIT = 3'b100
  } kshcp_state_t;
endpackage : kshcp_pkg

// File: design/kshcp_sync.sv
// Purpose: two-flop synchroniser plus edge detect for one pin
// Assumes: input is asynchronous to clk_i
// Notes:   edges derive only from the second and third stages
`timescale 1ns/1ns
module kshcp_sync (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  input  wire logic ce_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q;    // first stage, read only by the second
  logic sync_q;    // second stage
  logic prev_q;    // history for edge detect

  // reset to idle-high so the bus does not show a false edge
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      prev_q <= 1'b1;
    end else if (ce_i) begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign level_o = sync_q;
  assign rise_o  = sync_q & ~prev_q;
  assign fall_o  = ~sync_q & prev_q;
endmodule : kshcp_sync

// File: design/kshcp_port.sv
// Purpose: two-wire slave command port of a key-scan companion
// Assumes: scl/sda sampled by clk_i; key events arrive as one-cycle strobes
// Notes:   scl is stretched for one cycle at the start of each ack the device gives
//
// Overview of operation
// - address 0xa2 write, 0xa3 read; then command
// - address bits 7:1, direction in bit 0
// - receiver acks each byte; host nacks last
// - wake on bus activity; first address unacked
// - device may hold scl low; host waits
// - read-interrupt returns code, clears, releases irq
// - interrupt code: error, pin1, pin0, key bits
// - one pin enabled sets both pin bits
// - read-error returns error code and clears it
// - error bits: overflow, lost, keys, invalid, early
// - status codes: reset, wake, ack, nack
// - fourteen events; empty code ends data
// - repeat read returns same data, no advance
// - irq low on new event until code read
// - enabled pin edge wakes and asserts irq
// - debounce default 12 ms, command 0x22
// - active time default 500 ms; a write not above debounce is ignored
// - event byte msb one press, zero release
`timescale 1ns/1ns
module kshcp_port (
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  input  wire logic       ce_i,
  input  wire logic       scl_i,          // bus clock pin level
  output logic            scl_o,          // always 0 when driven
  output logic            scl_oe_o,       // high while stretching
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,       // high while pulling sda low
  output logic            irq_n_o,        // active-low interrupt request
  input  wire logic       key_evt_i,      // key event strobe
  input  wire logic [6:0] key_code_i,     // key number
  input  wire logic       key_press_i,    // 1 press, 0 release
  input  wire logic       key_over_i,     // more than two keys strobe
  input  wire logic       lost_int_i,     // interrupt withdrawn strobe
  input  wire logic       gen_pin_zero_i, // general_pin_zero
  input  wire logic       gen_pin_one_i,  // general_pin_one
  output logic            halted_o,       // device in halt mode
  output logic [7:0]      debounce_o,     // debounce setting
  output logic [7:0]      active_o,       // active time setting
  output logic            scan_req_o      // rescan request pulse
);
  // synchronised pins
  logic scl_s, scl_rise, scl_fall, sda_s, sda_rise, sda_fall;
  logic p0_s, p0_rise, p0_fall, p1_s, p1_rise, p1_fall;
  kshcp_sync u_scl (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .pin_i(scl_i),
                    .level_o(scl_s), .rise_o(scl_rise), .fall_o(scl_fall));
  kshcp_sync u_sda (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .pin_i(sda_i),
                    .level_o(sda_s), .rise_o(sda_rise), .fall_o(sda_fall));
  kshcp_sync u_p0  (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .pin_i(gen_pin_zero_i),
                    .level_o(p0_s), .rise_o(p0_rise), .fall_o(p0_fall));
  kshcp_sync u_p1  (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce_i), .pin_i(gen_pin_one_i),
                    .level_o(p1_s), .rise_o(p1_rise), .fall_o(p1_fall));

  kshcp_pkg::kshcp_state_t state_q;     // transaction state
  logic [7:0]  shift_q;                 // byte shifter
  logic [2:0]  bit_q;                   // bit count within byte
  logic        rd_q;                    // addressed for read
  logic        first_q;                 // next write byte is command
  logic [7:0]  cmd_q;                   // current command
  logic [4:0]  idx_q;                   // byte index in a read burst
  logic        halt_q;                  // halt mode
  logic        waking_q;                // woke on this frame, refuse address
  logic [7:0]  int_q;                   // interrupt_cause_code
  logic [7:0]  err_q;                   // error_cause_code
  logic [7:0]  stat_q;                  // command_status_code
  logic [1:0]  pin_en_q;                // pin interrupt enables
  logic [7:0]  deb_q;                   // debounce setting
  logic [7:0]  act_q;                   // active time setting
  logic        scan_q;                  // rescan pulse
  logic [7:0]  fifo_q [kshcp_pkg::FIFO_DEPTH];  // event storage
  logic [kshcp_pkg::PTR_W-1:0] wr_q;    // write pointer
  logic [kshcp_pkg::PTR_W-1:0] rdp_q;   // committed read pointer
  logic [kshcp_pkg::PTR_W:0]   cnt_q;   // stored events
  logic [23:0] idle_q;                  // cycles into the current active-time step
  logic [7:0]  steps_q;                 // elapsed active-time steps
  logic        irq_q;                   // irq asserted

  // wrap a pointer around the fourteen-entry buffer
  function automatic logic [kshcp_pkg::PTR_W-1:0] ptr_add(input logic [kshcp_pkg::PTR_W-1:0] p,
                                                          input logic [4:0] n);
    logic [5:0] s;
    s = {2'b00, p} + {1'b0, n};
    if (s >= 6'(2 * kshcp_pkg::FIFO_DEPTH)) s = s - 6'(2 * kshcp_pkg::FIFO_DEPTH);
    if (s >= 6'(kshcp_pkg::FIFO_DEPTH)) s = s - 6'(kshcp_pkg::FIFO_DEPTH);
    return s[kshcp_pkg::PTR_W-1:0];
  endfunction : ptr_add

  // bus conditions
  wire start_c  = sda_fall & scl_s;
  wire stop_c   = sda_rise & scl_s;
  wire byte_end = scl_rise & (bit_q == 3'd7);
  wire [7:0] rx_byte = {shift_q[6:0], sda_s};
  wire addr_hit = (rx_byte[7:1] == kshcp_pkg::SLAVE_ADDR);
  wire known_w  = (cmd_q == kshcp_pkg::CMD_DEBOUNCE) | (cmd_q == kshcp_pkg::CMD_PIN_INT_EN) |
                  (cmd_q == kshcp_pkg::CMD_ACTIVE);
  wire known_r  = (rx_byte == kshcp_pkg::CMD_EVENT_READ) | (rx_byte == kshcp_pkg::CMD_REPEAT_READ) |
                  (rx_byte == kshcp_pkg::CMD_READ_INT) | (rx_byte == kshcp_pkg::CMD_READ_STAT) |
                  (rx_byte == kshcp_pkg::CMD_READ_ERR) | (rx_byte == kshcp_pkg::CMD_SCAN_REQ) |
                  (rx_byte == kshcp_pkg::CMD_DEBOUNCE) | (rx_byte == kshcp_pkg::CMD_PIN_INT_EN) |
                  (rx_byte == kshcp_pkg::CMD_ACTIVE);
  wire is_fifo  = (cmd_q == kshcp_pkg::CMD_EVENT_READ) | (cmd_q == kshcp_pkg::CMD_REPEAT_READ);
  wire [4:0] cnt5 = cnt_q;
  // read data: events in order, then empty code
  // 0x20 pops as it goes, so it always reads the head; 0x21 walks by index instead
  wire [4:0] rd_off    = (cmd_q == kshcp_pkg::CMD_REPEAT_READ) ? idx_q : 5'd0;
  wire       rd_valid  = (rd_off < cnt5);
  wire [7:0] fifo_byte = rd_valid ? fifo_q[ptr_add(rdp_q, rd_off)] : kshcp_pkg::EMPTY_CODE;
  wire [7:0] tx_byte = (cmd_q == kshcp_pkg::CMD_READ_INT)  ? int_q :
                       (cmd_q == kshcp_pkg::CMD_READ_ERR)  ? err_q :
                       (cmd_q == kshcp_pkg::CMD_READ_STAT) ? stat_q :
                       is_fifo ? fifo_byte : kshcp_pkg::EMPTY_CODE;
  // a read byte is finished when the host acks or nacks it
  wire tx_done  = (state_q == kshcp_pkg::KSHCP_TACK) & scl_rise & (bit_q == 3'd0);
  wire tx_first = tx_done & (idx_q == 5'd0);
  // pin interrupt bits: one enabled pin sets both
  wire pin_hit  = (pin_en_q[0] & (p0_rise | p0_fall)) | (pin_en_q[1] & (p1_rise | p1_fall));
  wire [1:0] pin_bits = (pin_en_q == 2'b11) ? {p1_rise | p1_fall, p0_rise | p0_fall} :
                        (pin_hit ? 2'b11 : 2'b00);
  wire key_store = key_evt_i & (cnt_q < 5'(kshcp_pkg::FIFO_DEPTH));
  wire key_ovf   = key_evt_i & ~key_store;
  wire fifo_pop  = tx_done & (cmd_q == kshcp_pkg::CMD_EVENT_READ) & rd_valid & ~halt_q;
  wire cmd_bad   = byte_end & first_q & ~rd_q & (state_q == kshcp_pkg::KSHCP_RX) & ~known_r;
  wire err_new   = key_ovf | key_over_i | lost_int_i | cmd_bad;
  wire bus_act   = start_c | scl_fall;
  wire idle_step = (idle_q == 24'(kshcp_pkg::STEP_CYCLES - 1));

  // transaction engine, ack generation and scl stretch
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= kshcp_pkg::KSHCP_IDLE;
      shift_q <= 8'h00;
      bit_q   <= 3'd0;
      rd_q    <= 1'b0;
      first_q <= 1'b0;
      cmd_q   <= 8'h00;
      idx_q   <= 5'd0;
      sda_oe_o <= 1'b0;
      scl_oe_o <= 1'b0;
    end else if (ce_i) begin
      scl_oe_o <= 1'b0;
      if (start_c) begin                     // start or repeated start
        state_q <= kshcp_pkg::KSHCP_ADDR;
        bit_q   <= 3'd0;
        sda_oe_o <= 1'b0;
      end else if (stop_c) begin             // stop ends transmission
        state_q <= kshcp_pkg::KSHCP_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state_q)
          kshcp_pkg::KSHCP_ADDR, kshcp_pkg::KSHCP_RX: begin
            if (scl_rise) begin
              shift_q <= rx_byte;
              bit_q   <= bit_q + 3'd1;
            end
            if (byte_end && state_q == kshcp_pkg::KSHCP_ADDR) begin
              // start byte or halted wake: no ack
              if (addr_hit && !halt_q && !waking_q) begin
                rd_q    <= rx_byte[0];
                first_q <= ~rx_byte[0];
                idx_q   <= 5'd0;
                state_q <= kshcp_pkg::KSHCP_AACK;
              end else begin
                state_q <= kshcp_pkg::KSHCP_WAIT;
              end
            end else if (byte_end) begin
              if (first_q) cmd_q <= rx_byte;
              first_q <= 1'b0;
              state_q <= kshcp_pkg::KSHCP_RACK;
            end
          end
          kshcp_pkg::KSHCP_AACK, kshcp_pkg::KSHCP_RACK: begin
            if (scl_fall && !sda_oe_o) begin
              sda_oe_o <= 1'b1;              // ack low
              scl_oe_o <= 1'b1;              // one-cycle stretch while deciding
            end else if (scl_fall) begin
              sda_oe_o <= rd_q & ~tx_byte[7];
              bit_q    <= 3'd0;
              shift_q  <= {tx_byte[6:0], 1'b0};
              state_q  <= rd_q ? kshcp_pkg::KSHCP_TX : kshcp_pkg::KSHCP_RX;
            end
          end
          kshcp_pkg::KSHCP_TX: begin
            if (scl_fall) begin
              bit_q <= bit_q + 3'd1;
              if (bit_q == 3'd7) begin
                sda_oe_o <= 1'b0;            // release for host ack
                state_q  <= kshcp_pkg::KSHCP_TACK;
              end else begin
                sda_oe_o <= ~shift_q[7];
                shift_q  <= {shift_q[6:0], 1'b0};
              end
            end
          end
          kshcp_pkg::KSHCP_TACK: begin
            if (scl_rise && bit_q == 3'd0) begin
              idx_q <= idx_q + 5'd1;
              bit_q <= 3'd1;                 // host answer seen, wait for the fall
              if (sda_s) state_q <= kshcp_pkg::KSHCP_WAIT;  // nack ends
            end else if (scl_fall && bit_q == 3'd1) begin
              // next byte starts right away: no ack slot of our own in a read
              sda_oe_o <= ~tx_byte[7];
              bit_q    <= 3'd0;
              shift_q  <= {tx_byte[6:0], 1'b0};
              state_q  <= kshcp_pkg::KSHCP_TX;
            end
          end
          kshcp_pkg::KSHCP_WAIT: sda_oe_o <= 1'b0;
          default: state_q <= kshcp_pkg::KSHCP_IDLE;
        endcase
      end
    end
  end

  // event buffer storage and pointers
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      wr_q  <= '0;
      rdp_q <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      if (key_store) begin
        fifo_q[wr_q] <= {key_press_i, key_code_i};
        wr_q <= ptr_add(wr_q, 5'd1);
      end
      if (fifo_pop) rdp_q <= ptr_add(rdp_q, 5'd1);  // repeat read never pops
      cnt_q <= cnt_q + {4'd0, key_store} - {4'd0, fifo_pop};
    end
  end

  // interrupt, error and status codes; set wins over clear
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      int_q  <= 8'h00;
      err_q  <= 8'h00;
      stat_q <= kshcp_pkg::STAT_RESET;
      irq_q  <= 1'b0;
    end else if (ce_i) begin
      int_q <= ((tx_first && cmd_q == kshcp_pkg::CMD_READ_INT) ? 8'h00 : int_q)
               | {4'h0, err_new, pin_bits, key_evt_i};
      err_q <= ((tx_first && cmd_q == kshcp_pkg::CMD_READ_ERR) ? 8'h00 : err_q)
               | {1'b0, key_ovf, 1'b0, lost_int_i, 1'b0, key_over_i,
                  cmd_bad,
                  byte_end & (state_q == kshcp_pkg::KSHCP_ADDR) & addr_hit & (halt_q | waking_q)};
      if (key_evt_i || err_new || pin_hit) irq_q <= 1'b1;
      else if (tx_first && cmd_q == kshcp_pkg::CMD_READ_INT) irq_q <= 1'b0;
      if (pin_hit && halt_q) stat_q <= kshcp_pkg::STAT_WAKE;
      // reading the status must not overwrite the status it reports
      else if (byte_end && first_q && state_q == kshcp_pkg::KSHCP_RX && rx_byte != kshcp_pkg::CMD_READ_STAT)
        stat_q <= known_r ? kshcp_pkg::STAT_ACK : kshcp_pkg::STAT_NACK;
    end
  end

  // settings written by the host
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      deb_q    <= kshcp_pkg::DEBOUNCE_RST;
      act_q    <= kshcp_pkg::ACTIVE_RST;
      pin_en_q <= 2'b00;
      scan_q   <= 1'b0;
    end else if (ce_i) begin
      scan_q <= byte_end & first_q & (rx_byte == kshcp_pkg::CMD_SCAN_REQ) &
                (state_q == kshcp_pkg::KSHCP_RX);
      if (byte_end && !first_q && state_q == kshcp_pkg::KSHCP_RX && known_w) begin
        if (cmd_q == kshcp_pkg::CMD_DEBOUNCE && rx_byte != 8'h00) deb_q <= rx_byte;
        if (cmd_q == kshcp_pkg::CMD_ACTIVE && rx_byte > deb_q) act_q <= rx_byte;
        if (cmd_q == kshcp_pkg::CMD_PIN_INT_EN) pin_en_q <= rx_byte[1:0];
      end
    end
  end

  // halt and wake: activity or pin edge wakes; idle active-time enters halt
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      halt_q   <= 1'b0;
      waking_q <= 1'b0;
      idle_q   <= 24'd0;
      steps_q  <= 8'd0;
    end else if (ce_i) begin
      if (bus_act || pin_hit || key_evt_i) begin
        idle_q  <= 24'd0;
        steps_q <= 8'd0;
        if (halt_q && bus_act) waking_q <= 1'b1;  // this frame goes unacked
        halt_q <= 1'b0;
      end else begin
        idle_q <= idle_step ? 24'd0 : idle_q + 24'd1;
        if (idle_step) steps_q <= steps_q + 8'd1;
        if (idle_step && steps_q >= act_q && state_q == kshcp_pkg::KSHCP_IDLE) halt_q <= 1'b1;
      end
      if (stop_c) waking_q <= 1'b0;               // retry is acknowledged
    end
  end

  assign scl_o      = 1'b0;
  assign sda_o      = 1'b0;
  assign irq_n_o    = ~irq_q;
  assign halted_o   = halt_q;
  assign debounce_o = deb_q;
  assign active_o   = act_q;
  assign scan_req_o = scan_q;
endmodule : kshcp_port

// File: test/kshcp_checker.sv
// Purpose: port-level assertions for the key-scan command port
// Assumes: bound to every kshcp_port, one clock domain
// Notes:   halt is never reached in a short run
`timescale 1ns/1ns
module kshcp_checker (
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       ce_i,
  input wire logic       scl_o,
  input wire logic       scl_oe_o,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic       irq_n_o,
  input wire logic       key_evt_i,
  input wire logic       halted_o,
  input wire logic [7:0] debounce_o,
  input wire logic [7:0] active_o,
  input wire logic       scan_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // open-drain pins may only ever pull low
  chk_scl_pull_low: assert property (!scl_o)
    else $error("scl driven high");
  chk_sda_pull_low: assert property (!sda_o)
    else $error("sda driven high");
  // stretch is a single cycle so the host is never held long
  chk_stretch_one_cycle: assert property (scl_oe_o && ce_i |=> !scl_oe_o)
    else $error("stretch longer than one cycle");
  chk_scan_req_pulse: assert property (scan_req_o && ce_i |=> !scan_req_o)
    else $error("rescan request not a pulse");
  // settings and outputs right after reset release
  chk_reset_outputs: assert property ($rose(reset_n_i) |-> debounce_o == kshcp_pkg::DEBOUNCE_RST
    && active_o == kshcp_pkg::ACTIVE_RST && irq_n_o && !sda_oe_o && !halted_o)
    else $error("wrong values after reset");
  // a sleeping device never acknowledges
  chk_halt_no_ack: assert property (halted_o |-> !sda_oe_o)
    else $error("ack while halted");
  chk_key_irq: assert property (key_evt_i && ce_i |-> ##[1:4] !irq_n_o)
    else $error("key event without irq");
  // a dropped enable freezes irq, both settings and the sda drive
  chk_ce_freeze: assert property (!ce_i |=> $stable(irq_n_o) && $stable(debounce_o)
    && $stable(active_o) && $stable(sda_oe_o))
    else $error("state moved while disabled");
endmodule : kshcp_checker

bind kshcp_port kshcp_checker u_chk (.clk_i, .reset_n_i, .ce_i, .scl_o, .scl_oe_o, .sda_o, .sda_oe_o,
  .irq_n_o, .key_evt_i, .halted_o, .debounce_o, .active_o, .scan_req_o);

// File: test/kshcp_host.sv
// Purpose: two-wire bus master standing in for the host processor
// Assumes: wires resolved in the bench with pull-ups
// Notes:   320 ns bit period; start and stop phases run longer
`timescale 1ns/1ns
module kshcp_host (
  input  wire logic scl_i,    // resolved clock wire
  input  wire logic sda_i,    // resolved data wire
  output logic      scl_dn_o, // high pulls clock low
  output logic      sda_dn_o  // high pulls data low
);
  initial begin
    scl_dn_o = 1'b0;
    sda_dn_o = 1'b0;
  end
  // release clock, wait out stretching, then a full high phase
  task automatic sclk_up();
    scl_dn_o = 1'b0;
    for (int t = 0; t < 400 && !scl_i; t++) #40;
    #160;
  endtask : sclk_up
  // also serves as repeated start between commands
  task automatic start();
    sda_dn_o = 1'b0;
    #160;
    sclk_up();
    sda_dn_o = 1'b1;
    #160;
    scl_dn_o = 1'b1;
    #80;
  endtask : start
  task automatic stop();
    sda_dn_o = 1'b1;
    #80;
    sclk_up();
    sda_dn_o = 1'b0;
    #160;
  endtask : stop
  // data changes only while the clock is low
  task automatic bit_io(input logic b, output logic r);
    sda_dn_o = !b;
    #80;
    sclk_up();
    r = sda_i;
    scl_dn_o = 1'b1;
    #80;
  endtask : bit_io
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : wbyte
  // last byte is answered with a nack
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : rbyte
endmodule : kshcp_host

// File: test/tb_kshcp_port.sv
// Purpose: self-checking bench for the key-scan command port
// Assumes: host model on the pins, key events as strobes
// Notes:   halt entry is out of reach in a short run
`timescale 1ns/1ns
module tb_kshcp_port;
  logic       clk_i       = 1'b0; // system clock
  logic       reset_n_i   = 1'b0; // sync reset
  logic       ce_i        = 1'b1; // clock enable
  logic       key_evt_i   = 1'b0; // key strobe
  logic [6:0] key_code_i  = 7'h00;
  logic       key_press_i = 1'b0;
  logic       key_over_i  = 1'b0;
  logic       lost_int_i  = 1'b0;
  logic       pin0        = 1'b1; // general_pin_zero, idles high like its synchroniser
  logic       pin1        = 1'b1; // general_pin_one
  logic       scl_oe, sda_oe, irq_n_o, h_scl, h_sda, a, halted_o, scan_req_o;
  int         scan_seen   = 0;    // rescan pulses seen
  logic [7:0] debounce_o, active_o, act, d;
  logic [7:0] rq[$], ev[$];         // read bytes, expected events
  wire        scl_w = !(scl_oe | h_scl); // pulled-up wires
  wire        sda_w = !(sda_oe | h_sda);
  int         err_count = 0, check_count = 0;

  kshcp_port dut (.clk_i, .reset_n_i, .ce_i, .scl_i(scl_w), .scl_o(), .scl_oe_o(scl_oe), .sda_i(sda_w),
    .sda_o(), .sda_oe_o(sda_oe), .irq_n_o, .key_evt_i, .key_code_i, .key_press_i, .key_over_i,
    .lost_int_i, .gen_pin_zero_i(pin0), .gen_pin_one_i(pin1), .halted_o, .debounce_o, .active_o,
    .scan_req_o);
  kshcp_host u_host (.scl_i(scl_w), .sda_i(sda_w), .scl_dn_o(h_scl), .sda_dn_o(h_sda));

  always #20 clk_i = ~clk_i;
  // count rescan pulses away from the launching edge
  always @(negedge clk_i) if (scan_req_o === 1'b1) scan_seen++;

  task automatic close_out();
    if (err_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // byte that the device must acknowledge
  task automatic put(input logic [7:0] b);
    u_host.wbyte(b, a);
    chk({7'h00, a}, 8'h01);
  endtask : put
  task automatic wr(input logic [7:0] c, input logic [7:0] v, input logic nd);
    u_host.start();
    put(8'ha2);
    put(c);
    if (nd) put(v);
    u_host.stop();
  endtask : wr
  task automatic rd(input logic [7:0] c, input int n);
    logic [7:0] b;
    rq = {};
    u_host.start();
    put(8'ha2);
    put(c);
    u_host.start();
    put(8'ha3);
    for (int i = 0; i < n; i++) begin
      u_host.rbyte(i == n - 1, b);
      rq.push_back(b);
    end
    u_host.stop();
  endtask : rd
  // strobes are lost, over, key from high to low bit
  task automatic pulse(input logic [7:0] e, input logic [2:0] s);
    @(negedge clk_i);
    {key_press_i, key_code_i} = e;
    {lost_int_i, key_over_i, key_evt_i} = s;
    @(negedge clk_i);
    {lost_int_i, key_over_i, key_evt_i} = 3'b000;
  endtask : pulse
  // n events plus two errors, then the full service sequence
  task automatic keys(input int n);
    int m;
    logic [7:0] e;
    ev = {};
    m = (n > 14) ? 14 : n;
    for (int i = 0; i < n; i++) begin
      e = {1'($urandom), 7'($urandom_range(127, 1))};
      if (i < 14) ev.push_back(e);
      pulse(e, 3'b001);
    end
    pulse(8'h00, 3'b110);
    repeat (8) @(negedge clk_i);
    chk({7'h00, irq_n_o}, 8'h00);
    rd(8'hd0, 1);
    chk(rq[0], 8'h09);
    chk({7'h00, irq_n_o}, 8'h01);
    rd(8'hf0, 1);
    chk(rq[0], (n > 14) ? 8'h54 : 8'h14);
    // repeat read first, then the popping read must match it
    for (int k = 0; k < 2; k++) begin
      rd(k ? 8'h20 : 8'h21, m + 1);
      for (int i = 0; i <= m; i++) chk(rq[i], (i < m) ? ev[i] : 8'h00);
    end
    rd(8'h20, 1);
    chk(rq[0], 8'h00);
  endtask : keys
  task automatic pin(input logic [7:0] en, input logic w, input logic [7:0] x);
    wr(8'hd1, en, 1'b1);
    @(negedge clk_i);
    if (w) pin1 = !pin1;
    else pin0 = !pin0;
    repeat (8) @(negedge clk_i);
    chk({7'h00, irq_n_o}, 8'h00);
    rd(8'hd0, 1);
    chk(rq[0], x);
  endtask : pin

  // watchdog well beyond the expected run length
  initial begin
    #2_000_000;
    err_count++;
    close_out();
  end
  initial begin
    void'($urandom(32'hb296));
    repeat (3) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(8'he0, 1);
    chk(rq[0], 8'h00);
    // start byte and foreign address go unanswered
    for (int i = 0; i < 2; i++) begin
      u_host.start();
      u_host.wbyte(i ? 8'ha4 : 8'h01, a);
      u_host.stop();
      chk({7'h00, a}, 8'h00);
    end
    wr(8'h55, 8'h00, 1'b0);
    rd(8'he0, 1);
    chk(rq[0], 8'h15);
    rd(8'hd0, 1);
    chk(rq[0], 8'h08);
    rd(8'hf0, 1);
    chk(rq[0], 8'h02);
    rd(8'hf0, 1);
    chk(rq[0], 8'h00);
    rd(8'he0, 1);
    chk(rq[0], 8'h06);
    keys($urandom_range(5, 1));
    keys(15);
    // an active time not above debounce is ignored
    act = kshcp_pkg::ACTIVE_RST;
    repeat (3) begin
      d = 8'($urandom_range(253, 1));
      wr(8'h22, d, 1'b1);
      chk(debounce_o, d);
      wr(8'he4, d, 1'b1);
      chk(active_o, act);
      act = d + 8'h01;
      wr(8'he4, act, 1'b1);
      chk(active_o, act);
    end
    wr(8'he3, 8'h00, 1'b1);
    chk(8'(scan_seen), 8'h01);
    chk({7'h00, halted_o}, 8'h00);
    pin(8'h01, 1'b0, 8'h06);
    pin(8'h03, 1'b1, 8'h04);
    pin(8'h03, 1'b0, 8'h02);
    @(negedge clk_i);
    ce_i = 1'b0;
    repeat (4) @(negedge clk_i);
    ce_i = 1'b1;
    repeat (4) @(negedge clk_i);
    close_out();
  end
endmodule : tb_kshcp_port
